// [ebnre_pkg.sv]
// Purpose: constants for the external bus non-blocking read engine
// Assumes: 32-bit register port, one word per register
// Notes: offsets are byte addresses
//
// Contract
// - two independent read channels, 0 and 1
// - item size byte, halfword or word
// - start address relative to device zero
// - channel keeps address, continues sequentially
// - transfer length counts 1 to 4095
// - start launches autonomous fetches into FIFO
// - pause while FIFO full, resume after drain
// - stop cancels channel, no more fetches
// - FIFO item count readable
// - per-channel outstanding count readable
// - FIFO data read pops one item
// - write FIFO free slots readable
// - level event while fill above trigger
// - read stall error when enabled
// - write-full error when enabled
package ebnre_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned EXT_ADDR_W = 24;
  localparam int unsigned CNT_W = 12;
  localparam int unsigned FIFO_DEPTH = 8;
  localparam int unsigned FIFO_PTR_W = 3;
  localparam int unsigned WFIFO_DEPTH = 4;
  // register byte offsets
  localparam logic [7:0] REG_CFG0 = 8'h00;
  localparam logic [7:0] REG_CFG1 = 8'h04;
  localparam logic [7:0] REG_ADDR0 = 8'h08;
  localparam logic [7:0] REG_ADDR1 = 8'h0c;
  localparam logic [7:0] REG_START0 = 8'h10;
  localparam logic [7:0] REG_START1 = 8'h14;
  localparam logic [7:0] REG_STOP = 8'h18;
  localparam logic [7:0] REG_AVAIL = 8'h1c;
  localparam logic [7:0] REG_DATA = 8'h20;
  localparam logic [7:0] REG_WFREE = 8'h24;
  localparam logic [7:0] REG_FIFOCFG = 8'h28;
  localparam logic [7:0] REG_STATUS = 8'h2c;
  localparam logic [7:0] REG_MASK = 8'h30;
  // item size encodings
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;
  // fifo config fields
  localparam int unsigned FC_TRIG_LSB = 0;
  localparam int unsigned FC_RSTALL_BIT = 4;
  localparam int unsigned FC_WFULL_BIT = 5;
  // status bits
  localparam int unsigned ST_LEVEL = 0;
  localparam int unsigned ST_RSTALL = 1;
  localparam int unsigned ST_WFULL = 2;
  localparam int unsigned ST_W = 3;
  typedef enum logic [1:0] {
    EBN_IDLE = 2'b00,
    EBN_REQ = 2'b01,
    EBN_WAIT = 2'b10
  } ebnre_state_type;
endpackage

// [ebnre_fifo.sv]
// Purpose: read FIFO holding fetched items
// Assumes: push never when full, pop never when empty
// Notes: count output gives occupancy
`timescale 1ns/1ps
module ebnre_fifo
  import ebnre_pkg::*;
(
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic flush_in,
  input wire logic push_in,
  input wire logic [31:0] push_data_in,
  input wire logic pop_in,
  output logic [31:0] pop_data_out,
  output logic [FIFO_PTR_W:0] count_out
);
  logic [31:0] mem_ff [FIFO_DEPTH];
  logic [FIFO_PTR_W-1:0] wr_ff, nxt_wr, rd_ff, nxt_rd;
  logic [FIFO_PTR_W:0] cnt_ff, nxt_cnt;

  always_comb
  begin
    nxt_wr = wr_ff;
    nxt_rd = rd_ff;
    nxt_cnt = cnt_ff;
    if (flush_in)
    begin
      nxt_wr = '0;
      nxt_rd = '0;
      nxt_cnt = '0;
    end
    else
    begin
      if (push_in)
        nxt_wr = wr_ff + 1'b1;
      if (pop_in)
        nxt_rd = rd_ff + 1'b1;
      nxt_cnt = cnt_ff + {{FIFO_PTR_W{1'b0}}, push_in}
                - {{FIFO_PTR_W{1'b0}}, pop_in};
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      wr_ff <= '0;
      rd_ff <= '0;
      cnt_ff <= '0;
    end
    else
    begin
      wr_ff <= nxt_wr;
      rd_ff <= nxt_rd;
      cnt_ff <= nxt_cnt;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (push_in && !flush_in)
      mem_ff[wr_ff] <= push_data_in;
  end

  assign pop_data_out = mem_ff[rd_ff];
  assign count_out = cnt_ff;
endmodule

// [ebnre_top.sv]
// Purpose: non-blocking read engine of the external bus interface
// Assumes: external device answers each read with a one-cycle ack
// Notes: channel 0 wins when both channels are pending
`timescale 1ns/1ps
module ebnre_top
  import ebnre_pkg::*;
(
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic [ebnre_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  output logic ext_req_out,
  output logic [ebnre_pkg::EXT_ADDR_W-1:0] ext_addr_out,
  output logic [1:0] ext_size_out,
  input wire logic ext_ack_in,
  input wire logic [31:0] ext_rdata_in,
  input wire logic ext_busy_in,
  input wire logic [2:0] wfifo_used_in,
  input wire logic wfifo_push_in,
  output logic irq_out
);
  import ebnre_pkg::*;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] ack_s_ff, busy_s_ff;
  logic [31:0] rdata_s1_ff, rdata_s2_ff;
  logic ack_q, busy_q;
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      ack_s_ff <= '0;
      busy_s_ff <= '0;
      rdata_s1_ff <= '0;
      rdata_s2_ff <= '0;
    end
    else
    begin
      ack_s_ff <= {ack_s_ff[0], ext_ack_in};
      busy_s_ff <= {busy_s_ff[0], ext_busy_in};
      rdata_s1_ff <= ext_rdata_in;
      rdata_s2_ff <= rdata_s1_ff;
    end
  end
  assign ack_q = ack_s_ff[1];
  assign busy_q = busy_s_ff[1];

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  logic wr_stop, wr_fcfg, wr_stat, wr_mask, rd_data;
  logic [1:0] wr_cfg, wr_addr, wr_start;
  assign wr_cfg = {reg_wr_in && reg_addr_in == REG_CFG1,
                   reg_wr_in && reg_addr_in == REG_CFG0};
  assign wr_addr = {reg_wr_in && reg_addr_in == REG_ADDR1,
                    reg_wr_in && reg_addr_in == REG_ADDR0};
  assign wr_start = {reg_wr_in && reg_addr_in == REG_START1,
                     reg_wr_in && reg_addr_in == REG_START0};
  assign wr_stop = reg_wr_in && reg_addr_in == REG_STOP;
  assign wr_fcfg = reg_wr_in && reg_addr_in == REG_FIFOCFG;
  assign wr_stat = reg_wr_in && reg_addr_in == REG_STATUS;
  assign wr_mask = reg_wr_in && reg_addr_in == REG_MASK;
  assign rd_data = reg_rd_in && reg_addr_in == REG_DATA;

  // ----------------------------------------------------------------
  // channel state
  // ----------------------------------------------------------------
  logic [1:0] size_ff [2];
  logic [1:0] nxt_size [2];
  logic [EXT_ADDR_W-1:0] addr_ff [2];
  logic [EXT_ADDR_W-1:0] nxt_addr [2];
  logic [CNT_W-1:0] left_ff [2];
  logic [CNT_W-1:0] nxt_left [2];
  logic [CNT_W-1:0] inflight_left [2];
  ebnre_state_type st_ff, nxt_st;
  logic cur_ff, nxt_cur;
  logic [FIFO_PTR_W:0] fifo_cnt;
  logic [31:0] fifo_dout;
  logic push, fifo_full;
  logic [EXT_ADDR_W-1:0] step;

  // one request in flight at most, so the count alone decides fullness
  assign fifo_full = fifo_cnt == (FIFO_PTR_W+1)'(FIFO_DEPTH);
  assign push = (st_ff == EBN_WAIT) && ack_q;
  assign step = (size_ff[cur_ff] == SIZE_WORD) ? EXT_ADDR_W'(4) :
                (size_ff[cur_ff] == SIZE_HALF) ? EXT_ADDR_W'(2) :
                EXT_ADDR_W'(1);

  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_chan
      always_comb
      begin
        nxt_size[g] = size_ff[g];
        nxt_addr[g] = addr_ff[g];
        nxt_left[g] = left_ff[g];
        if (wr_cfg[g])
          nxt_size[g] = reg_wdata_in[1:0];
        if (push && cur_ff == g)
        begin
          nxt_addr[g] = addr_ff[g] + step;
          nxt_left[g] = left_ff[g] - 1'b1;
        end
        // address is device-relative, zero is the first location
        if (wr_addr[g])
          nxt_addr[g] = reg_wdata_in[EXT_ADDR_W-1:0];
        if (wr_start[g] && reg_wdata_in[CNT_W-1:0] != '0)
          nxt_left[g] = reg_wdata_in[CNT_W-1:0];
        if (wr_stop && reg_wdata_in[g])
          nxt_left[g] = '0;
      end
      always_ff @(posedge clk_in or negedge resetn_in)
      begin
        if (!resetn_in)
        begin
          size_ff[g] <= SIZE_BYTE;
          addr_ff[g] <= '0;
          left_ff[g] <= '0;
        end
        else
        begin
          size_ff[g] <= nxt_size[g];
          addr_ff[g] <= nxt_addr[g];
          left_ff[g] <= nxt_left[g];
        end
      end
      assign inflight_left[g] = left_ff[g];
    end
  endgenerate

  // ----------------------------------------------------------------
  // fetch sequencer
  // ----------------------------------------------------------------
  logic [31:0] item;
  logic stall_evt;
  always_comb
  begin
    nxt_st = st_ff;
    nxt_cur = cur_ff;
    stall_evt = 1'b0;
    case (st_ff)
      EBN_IDLE:
      begin
        if (left_ff[0] != '0 || left_ff[1] != '0)
        begin
          nxt_cur = (left_ff[0] != '0) ? 1'b0 : 1'b1;
          if (busy_q)
            stall_evt = 1'b1;
          else if (!fifo_full)
            nxt_st = EBN_REQ;
        end
      end
      EBN_REQ:
        nxt_st = EBN_WAIT;
      EBN_WAIT:
      begin
        if (ack_q)
          nxt_st = EBN_IDLE;
        else if (left_ff[cur_ff] == '0)
          nxt_st = EBN_IDLE;
      end
      default:
        nxt_st = EBN_IDLE;
    endcase
  end

  always_comb
  begin
    case (size_ff[cur_ff])
      SIZE_WORD: item = rdata_s2_ff;
      SIZE_HALF: item = {16'h0000, rdata_s2_ff[15:0]};
      default: item = {24'h000000, rdata_s2_ff[7:0]};
    endcase
  end

  logic fifo_push;
  assign fifo_push = push && left_ff[cur_ff] != '0;

  ebnre_fifo u_fifo (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .flush_in(1'b0),
    .push_in(fifo_push),
    .push_data_in(item),
    .pop_in(rd_data && fifo_cnt != '0),
    .pop_data_out(fifo_dout),
    .count_out(fifo_cnt)
  );

  // ----------------------------------------------------------------
  // interrupts and config
  // ----------------------------------------------------------------
  logic [7:0] fcfg_ff, nxt_fcfg;
  logic [ST_W-1:0] stat_ff, nxt_stat, mask_ff, nxt_mask, evt;
  logic [31:0] rdata_ff, nxt_rdata;
  logic req_ff, irq_ff;
  logic [EXT_ADDR_W-1:0] eaddr_ff;
  logic [1:0] esize_ff;
  logic [2:0] wfree;
  assign wfree = 3'(WFIFO_DEPTH) - wfifo_used_in;

  always_comb
  begin
    evt = '0;
    evt[ST_LEVEL] = {1'b0, fifo_cnt} > {1'b0, fcfg_ff[3:0]};
    evt[ST_RSTALL] = stall_evt && fcfg_ff[FC_RSTALL_BIT];
    evt[ST_WFULL] = wfifo_push_in && wfifo_used_in == 3'(WFIFO_DEPTH)
                    && fcfg_ff[FC_WFULL_BIT];
    nxt_fcfg = wr_fcfg ? reg_wdata_in[7:0] : fcfg_ff;
    nxt_mask = wr_mask ? reg_wdata_in[ST_W-1:0] : mask_ff;
    // a set in the same cycle beats the write-one clear
    nxt_stat = (stat_ff & ~(wr_stat ? reg_wdata_in[ST_W-1:0] : '0)) | evt;
    nxt_rdata = 32'h00000000;
    if (reg_rd_in)
      case (reg_addr_in)
        REG_CFG0: nxt_rdata = {30'h0, size_ff[0]};
        REG_CFG1: nxt_rdata = {30'h0, size_ff[1]};
        REG_ADDR0: nxt_rdata = {8'h00, addr_ff[0]};
        REG_ADDR1: nxt_rdata = {8'h00, addr_ff[1]};
        REG_START0: nxt_rdata = {20'h0, inflight_left[0]};
        REG_START1: nxt_rdata = {20'h0, inflight_left[1]};
        REG_AVAIL: nxt_rdata = {28'h0, fifo_cnt};
        REG_DATA: nxt_rdata = (fifo_cnt != '0) ? fifo_dout : 32'h0;
        REG_WFREE: nxt_rdata = {29'h0, wfree};
        REG_FIFOCFG: nxt_rdata = {24'h0, fcfg_ff};
        REG_STATUS: nxt_rdata = {29'h0, stat_ff};
        REG_MASK: nxt_rdata = {29'h0, mask_ff};
        default: nxt_rdata = 32'h00000000;
      endcase
  end

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      st_ff <= EBN_IDLE;
      cur_ff <= 1'b0;
      fcfg_ff <= 8'h00;
      stat_ff <= '0;
      mask_ff <= '0;
      rdata_ff <= 32'h0;
      req_ff <= 1'b0;
      eaddr_ff <= '0;
      esize_ff <= SIZE_BYTE;
      irq_ff <= 1'b0;
    end
    else
    begin
      st_ff <= nxt_st;
      cur_ff <= nxt_cur;
      fcfg_ff <= nxt_fcfg;
      stat_ff <= nxt_stat;
      mask_ff <= nxt_mask;
      rdata_ff <= nxt_rdata;
      req_ff <= (nxt_st == EBN_REQ);
      eaddr_ff <= addr_ff[nxt_cur];
      esize_ff <= size_ff[nxt_cur];
      irq_ff <= |(nxt_stat & nxt_mask);
    end
  end

  assign reg_rdata_out = rdata_ff;
  assign ext_req_out = req_ff;
  assign ext_addr_out = eaddr_ff;
  assign ext_size_out = esize_ff;
  assign irq_out = irq_ff;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_full_no_req: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (st_ff == EBN_IDLE && fifo_cnt == (FIFO_PTR_W+1)'(FIFO_DEPTH))
    |=> !ext_req_out) else $error("fetch issued with full fifo");
  chk_stop_clears: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (wr_stop && reg_wdata_in[0]) |=> left_ff[0] == '0)
    else $error("stop did not clear count");
  chk_stop_one: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (wr_stop && reg_wdata_in[1]) |=> left_ff[1] == '0)
    else $error("stop did not clear second count");
  chk_push_dec: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (fifo_push && !cur_ff && !wr_start[0] && !wr_stop)
    |=> left_ff[0] == $past(left_ff[0]) - 1'b1)
    else $error("count not decremented");
  chk_start_load: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (wr_start[1] && reg_wdata_in[11:0] != 12'h000 && !wr_stop)
    |=> left_ff[1] == $past(reg_wdata_in[11:0]))
    else $error("start count not loaded");
  chk_avail_read: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (reg_rd_in && reg_addr_in == REG_AVAIL)
    |=> reg_rdata_out == {28'h0, $past(fifo_cnt)})
    else $error("avail readback wrong");
  chk_idle_launch: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (st_ff == EBN_IDLE && left_ff[0] != '0 && !busy_q && fifo_cnt == '0)
    |=> ext_req_out && ext_addr_out == $past(addr_ff[0]))
    else $error("fetch not launched");
  chk_stat_sticky: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (stat_ff[ST_RSTALL] && !wr_stat) |=> stat_ff[ST_RSTALL])
    else $error("status bit lost");
  chk_addr_step: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (push && cur_ff && size_ff[1] == SIZE_WORD && !wr_addr[1])
    |=> addr_ff[1] == $past(addr_ff[1]) + EXT_ADDR_W'(4))
    else $error("address not advanced");
endmodule

// [ebnre_ext_dev.sv]
// Purpose: external device model answering engine reads
// Assumes: one read in flight, address is device relative
// Notes: slow_in stretches the ack latency
`timescale 1ns/1ps
module ebnre_ext_dev
  import ebnre_pkg::*;
(
  input wire logic clk_in,
  input wire logic req_in,
  input wire logic [ebnre_pkg::EXT_ADDR_W-1:0] addr_in,
  input wire logic slow_in,
  output logic ack_out,
  output logic [31:0] rdata_out,
  output int reqs_out
);
  logic [EXT_ADDR_W-1:0] held;
  // ----------------------------------------
  // answer each request, data framed by ack
  // ----------------------------------------
  initial
  begin
    ack_out = 1'b0;
    rdata_out = 32'h0;
    reqs_out = 0;
    forever
    begin
      @(posedge clk_in);
      if (req_in)
      begin
        held = addr_in;
        reqs_out <= reqs_out + 1;
        repeat (slow_in ? 12 : 1) @(posedge clk_in);
        rdata_out <= {held[7:0] ^ 8'h3c, held};
        @(posedge clk_in);
        ack_out <= 1'b1;
        @(posedge clk_in);
        ack_out <= 1'b0;
        @(posedge clk_in);
        // hold time over: show the inverse
        rdata_out <= ~rdata_out;
      end
    end
  end
endmodule

// [test_external_bus_nonblocking_read_engine.sv]
// Purpose: self-checking bench for the non-blocking read engine
// Assumes: device model answers every request once
// Notes: read data matched against a queue of expected words
`timescale 1ns/1ps
module test_external_bus_nonblocking_read_engine;
  import ebnre_pkg::*;
  logic clk_in, resetn_in, reg_wr_in, reg_rd_in, ext_busy_in;
  logic wfifo_push_in, ext_ack_in, ext_req_out, irq_out, slow;
  logic rd_d = 1'b0;
  logic [7:0] reg_addr_in;
  logic [31:0] reg_wdata_in, reg_rdata_out, ext_rdata_in;
  logic [23:0] ext_addr_out, a, b;
  logic [2:0] wfifo_used_in;
  logic [1:0] ext_size_out;
  logic [31:0] expq[$];
  int num_errors, checked, reqs, r, n;
  ebnre_top ebnre_top_inst (.clk_in, .resetn_in, .reg_addr_in,
    .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .ext_req_out,
    .ext_addr_out, .ext_size_out, .ext_ack_in, .ext_rdata_in,
    .ext_busy_in, .wfifo_used_in, .wfifo_push_in, .irq_out);
  ebnre_ext_dev ebnre_ext_dev_inst (.clk_in, .req_in(ext_req_out),
    .addr_in(ext_addr_out), .slow_in(slow), .ack_out(ext_ack_in),
    .rdata_out(ext_rdata_in), .reqs_out(reqs));
  initial
  begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  function automatic logic [31:0] item(logic [23:0] x, int s);
    logic [31:0] w;
    w = {x[7:0] ^ 8'h3c, x};
    return s == 0 ? w & 32'hff : s == 1 ? w & 32'hffff : w;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // read data stands one cycle after the strobe
  always @(posedge clk_in)
  begin
    if (rd_d)
      check(reg_rdata_out, expq.pop_front());
    rd_d <= reg_rd_in;
  end
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk_in);
    reg_addr_in <= ad;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad, input logic [31:0] e);
    expq.push_back(e);
    @(posedge clk_in);
    reg_addr_in <= ad;
    reg_rd_in <= 1'b1;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
  endtask
  task automatic wpush();
    @(posedge clk_in);
    wfifo_push_in <= 1'b1;
    @(posedge clk_in);
    wfifo_push_in <= 1'b0;
  endtask
  task automatic irq_is(input logic v);
    repeat (3) @(posedge clk_in);
    check(irq_out, v);
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wait_acks(input int k);
    int t;
    t = 0;
    while (k > 0 && t < 400)
    begin
      @(posedge clk_in);
      k = k - int'(ext_ack_in);
      t++;
    end
    if (k > 0)
    begin
      num_errors++;
      $display("unexpected at %0t: ack wait ran out", $time);
      results();
    end
    else
      repeat (4) @(posedge clk_in);
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    {resetn_in, reg_wr_in, reg_rd_in, ext_busy_in} = 4'h0;
    {wfifo_push_in, slow} = 2'h0;
    reg_addr_in = 8'h0;
    reg_wdata_in = 32'h0;
    wfifo_used_in = 3'h0;
    num_errors = 0;
    checked = 0;
    void'($urandom(32'h48f5));
    repeat (16) @(posedge clk_in);
    resetn_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    rd(REG_AVAIL, 32'h0);
    rd(8'h3c, 32'h0);
    for (int u = 0; u <= 4; u++)
    begin
      wfifo_used_in <= u[2:0];
      rd(REG_WFREE, 32'(4 - u));
    end
    wpush();
    rd(REG_STATUS, 32'h0);
    wr(REG_FIFOCFG, 32'h20);
    wpush();
    rd(REG_STATUS, 32'h4);
    irq_is(1'b0);
    wr(REG_MASK, 32'h4);
    irq_is(1'b1);
    wr(REG_STATUS, 32'h4);
    irq_is(1'b0);
    wfifo_used_in <= 3'h0;
    $display("test write fifo done");
    a = 24'($urandom) & 24'h0fffff;
    for (int s = 0; s < 3; s++)
    begin
      wr(REG_CFG0, 32'(s));
      if (s == 0)
        wr(REG_ADDR0, {8'h0, a});
      wr(REG_START0, 32'h2);
      wait_acks(2);
      check({30'h0, ext_size_out}, 32'(s));
      rd(REG_AVAIL, 32'h2);
      rd(REG_START0, 32'h0);
      for (int i = 0; i < 2; i++)
      begin
        rd(REG_DATA, item(a, s));
        a = a + 24'(1 << s);
      end
    end
    rd(REG_DATA, 32'h0);
    $display("test sizes done");
    b = 24'($urandom);
    n = 1 + int'($urandom % 4);
    wr(REG_CFG1, 32'h2);
    wr(REG_ADDR1, {8'h0, b});
    wr(REG_START0, 32'h3);
    wr(REG_START1, 32'(n));
    wait_acks(3 + n);
    rd(REG_AVAIL, 32'(3 + n));
    for (int i = 0; i < 3 + n; i++)
    begin
      rd(REG_DATA, i < 3 ? item(a, 2) : item(b, 2));
      if (i < 3)
        a = a + 24'h4;
      else
        b = b + 24'h4;
    end
    $display("test two channels done");
    r = reqs;
    wr(REG_START0, 32'ha);
    wait_acks(8);
    repeat (30) @(posedge clk_in);
    check(32'(reqs - r), 32'h8);
    rd(REG_AVAIL, 32'h8);
    rd(REG_START0, 32'h2);
    wr(REG_FIFOCFG, 32'h3);
    wr(REG_STATUS, 32'h7);
    wr(REG_MASK, 32'h1);
    rd(REG_STATUS, 32'h1);
    irq_is(1'b1);
    for (int i = 0; i < 10; i++)
    begin
      rd(REG_DATA, item(a, 2));
      a = a + 24'h4;
      if (i == 2)
        wait_acks(2);
    end
    wr(REG_STATUS, 32'h1);
    rd(REG_STATUS, 32'h0);
    $display("test fifo full done");
    slow <= 1'b1;
    r = reqs;
    wr(REG_START1, 32'h0);
    rd(REG_START1, 32'h0);
    wr(REG_START1, 32'hfff);
    rd(REG_START1, 32'hfff);
    wait_acks(1);
    rd(REG_START1, 32'hffe);
    wr(REG_STOP, 32'h3);
    rd(REG_START1, 32'h0);
    repeat (40) @(posedge clk_in);
    check(32'(reqs - r), 32'h2);
    rd(REG_AVAIL, 32'h1);
    rd(REG_DATA, item(b, 2));
    $display("test stop done");
    slow <= 1'b0;
    wr(REG_FIFOCFG, 32'h13);
    wr(REG_STATUS, 32'h7);
    wr(REG_MASK, 32'h2);
    ext_busy_in <= 1'b1;
    r = reqs;
    wr(REG_START0, 32'h1);
    repeat (20) @(posedge clk_in);
    check(32'(reqs - r), 32'h0);
    rd(REG_STATUS, 32'h2);
    irq_is(1'b1);
    ext_busy_in <= 1'b0;
    wait_acks(1);
    rd(REG_DATA, item(a, 2));
    wr(REG_STATUS, 32'h2);
    irq_is(1'b0);
    $display("test read stall done");
    repeat (3) @(posedge clk_in);
    results();
  end
endmodule
